// ==== hdl/bridge_error_clock_run_control_retry_options.sv ====
`timescale 1ns/1ps
`default_nettype none

module bridge_error_clock_run_control_retry_options #(
	parameter int PORTS = 2
) (
	// Clock and reset
	input  wire logic                             clk_i,
	input  wire logic                             srst_i,
	// APB slave
	input  wire logic                             psel_i,
	input  wire logic                             penable_i,
	input  wire logic                             pwrite_i,
	input  wire logic [bridge_opts_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [bridge_opts_pkg::DATA_W-1:0] pwdata_i,
	output logic [bridge_opts_pkg::DATA_W-1:0]      prdata_o,
	output logic                                  pready_o,
	output logic                                  pslverr_o,
	// Error causes, one-cycle pulses when the error pin is asserted
	input  wire logic [bridge_opts_pkg::SERR_W-1:0] serr_cause_i,
	// Clock run
	input  wire logic                             pri_stop_req_i,
	input  wire logic                             pri_req_pending_i,
	input  wire logic                             sec_bus_idle_i,
	output logic                                  sec_clk_stop_o,
	output logic                                  pri_clk_stop_ok_o,
	// Retry matching, index 0 primary, index 1 secondary
	input  wire logic [PORTS-1:0][3:0]            retry_cmd_i,
	input  wire logic [PORTS-1:0][3:0]            pend_cmd_i,
	input  wire logic [PORTS-1:0]                 pend_nonposted_i,
	output logic [PORTS-1:0]                      retry_match_o
);
	import bridge_opts_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [SERR_W-1:0] serr_reg;
	logic [OPT_W-1:0]  opt_reg;
	logic              sec_en_reg;
	logic              pri_keep_reg;
	logic              pri_en_reg;
	logic              mode_reg;
	logic [DATA_W-1:0] prdata_reg;
	logic [PORTS-1:0]  match_reg;
	sec_clk_state_t    state_reg;
	sec_clk_state_t    state_next;

	logic setup;
	logic wr_acc;
	logic mapped;
	logic stop_cond;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == ADDR_SERR_STATUS) || (a == ADDR_CLOCK_RUN_CONTROL)
			|| (a == ADDR_PORT_OPTION);
	endfunction : is_mapped

	function automatic logic is_line_or_mult(input logic [3:0] c);
		is_line_or_mult = (c == memory_read_line_cmd)
			|| (c == memory_read_multiple_cmd);
	endfunction : is_line_or_mult

	// ----------------------------------------------------------------
	// APB access
	// ----------------------------------------------------------------
	// One wait-free access phase; read data is captured in setup so
	// that it comes from a flip-flop.
	assign setup     = psel_i & ~penable_i;
	assign mapped    = is_mapped(paddr_i);
	assign wr_acc    = psel_i & penable_i & pwrite_i & mapped;
	assign pready_o  = psel_i & penable_i;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign prdata_o  = prdata_reg;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prdata_reg <= '0;
		end else if (setup) begin
			prdata_reg <= '0;
			if (paddr_i == ADDR_SERR_STATUS) begin
				prdata_reg[SERR_LSB +: SERR_W] <= serr_reg;
			end else if (paddr_i == ADDR_CLOCK_RUN_CONTROL) begin
				prdata_reg[CR_SEC_STOP] <= (state_reg == CLK_STOPPED);
				prdata_reg[CR_SEC_EN]   <= sec_en_reg;
				prdata_reg[CR_PRI_KEEP] <= pri_keep_reg;
				prdata_reg[CR_PRI_EN]   <= pri_en_reg;
				prdata_reg[CR_MODE]     <= mode_reg;
			end else if (paddr_i == ADDR_PORT_OPTION) begin
				prdata_reg[OPT_LSB +: OPT_W] <= opt_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Error cause flags
	// ----------------------------------------------------------------
	// A cause arriving in the clearing cycle wins, so no event is lost.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			serr_reg <= SERR_RST;
		end else begin
			if (wr_acc && paddr_i == ADDR_SERR_STATUS) begin
				serr_reg <= (serr_reg & ~pwdata_i[SERR_LSB +: SERR_W])
					| serr_cause_i;
			end else begin
				serr_reg <= serr_reg | serr_cause_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Clock run control
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sec_en_reg   <= 1'b0;
			pri_keep_reg <= 1'b0;
			pri_en_reg   <= 1'b0;
			mode_reg     <= 1'b0;
		end else if (wr_acc && paddr_i == ADDR_CLOCK_RUN_CONTROL) begin
			sec_en_reg   <= pwdata_i[CR_SEC_EN];
			pri_keep_reg <= pwdata_i[CR_PRI_KEEP];
			pri_en_reg   <= pwdata_i[CR_PRI_EN];
			mode_reg     <= pwdata_i[CR_MODE];
		end
	end

	always_comb begin
		if (mode_reg) begin
			stop_cond = sec_bus_idle_i & ~pri_req_pending_i;
		end else begin
			stop_cond = pri_stop_req_i;
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CLK_RUNNING: begin
				if (sec_en_reg && stop_cond) begin
					state_next = CLK_STOPPED;
				end
			end
			CLK_STOPPED: begin
				if (!sec_en_reg || !stop_cond) begin
					state_next = CLK_RUNNING;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= CLK_RUNNING;
		end else begin
			state_reg <= state_next;
		end
	end

	// The primary side may only let go once the secondary has stopped.
	assign sec_clk_stop_o    = (state_reg == CLK_STOPPED);
	assign pri_clk_stop_ok_o = pri_en_reg & ~pri_keep_reg
		& (state_reg == CLK_STOPPED);

	// ----------------------------------------------------------------
	// Retry command matching
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			opt_reg <= OPT_RST;
		end else if (wr_acc && paddr_i == ADDR_PORT_OPTION) begin
			opt_reg <= pwdata_i[OPT_LSB +: OPT_W];
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < PORTS; gp++) begin : g_port
			logic rd_al;
			logic wr_al;
			logic rlm_al;
			logic hit;
			// Port 0 uses primary options, others secondary.
			assign rd_al  = (gp == 0) ? opt_reg[OPT_P_RD - OPT_LSB]
				: opt_reg[OPT_S_RD - OPT_LSB];
			assign wr_al  = (gp == 0) ? opt_reg[OPT_P_WR - OPT_LSB]
				: opt_reg[OPT_S_WR - OPT_LSB];
			assign rlm_al = (gp == 0) ? opt_reg[OPT_P_RLM - OPT_LSB]
				: opt_reg[OPT_S_RLM - OPT_LSB];
			always_comb begin
				hit = (retry_cmd_i[gp] == pend_cmd_i[gp]);
				if (rd_al && is_line_or_mult(retry_cmd_i[gp])
					&& pend_cmd_i[gp] == plain_memory_read_cmd) begin
					hit = 1'b1;
				end
				if (wr_al && pend_nonposted_i[gp]
					&& retry_cmd_i[gp] == write_and_invalidate_cmd
					&& pend_cmd_i[gp] == plain_memory_write_cmd) begin
					hit = 1'b1;
				end
				if (rlm_al && is_line_or_mult(retry_cmd_i[gp])
					&& is_line_or_mult(pend_cmd_i[gp])) begin
					hit = 1'b1;
				end
			end
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					match_reg[gp] <= 1'b0;
				end else begin
					match_reg[gp] <= hit;
				end
			end
		end
	endgenerate

	assign retry_match_o = match_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	logic sec_stopped;
	logic serr_clr;
	assign sec_stopped = (state_reg == CLK_STOPPED);
	assign serr_clr = wr_acc && paddr_i == ADDR_SERR_STATUS;

	cause_sets_a: assert property (
		(serr_cause_i != '0) |=> ((serr_reg & $past(serr_cause_i))
			== $past(serr_cause_i)))
		else $error("Error cause not recorded.");

	cause_holds_a: assert property (
		!serr_clr && serr_cause_i == '0 |=> $stable(serr_reg))
		else $error("Error cause changed without a write.");

	cause_clear_a: assert property (
		serr_clr |=> ((serr_reg & $past(pwdata_i[SERR_LSB +: SERR_W])
			& ~$past(serr_cause_i)) == '0))
		else $error("Error cause not cleared by write one.");

	cause_zero_keep_a: assert property (
		serr_clr |=> ((serr_reg & ~$past(pwdata_i[SERR_LSB +: SERR_W]))
			== (($past(serr_reg) | $past(serr_cause_i))
			& ~$past(pwdata_i[SERR_LSB +: SERR_W]))))
		else $error("Zero write disturbed a cause flag.");

	stop_status_a: assert property (
		setup && paddr_i == ADDR_CLOCK_RUN_CONTROL
		|=> prdata_o[CR_SEC_STOP] == $past(sec_stopped))
		else $error("Stop status misreported.");

	sec_disabled_a: assert property (
		!sec_en_reg |=> !sec_stopped)
		else $error("Secondary clock stopped while disabled.");

	pri_allow_a: assert property (
		pri_clk_stop_ok_o |-> pri_en_reg && !pri_keep_reg && sec_stopped)
		else $error("Primary stop allowed wrongly.");

	mode_req_a: assert property (
		sec_en_reg && !mode_reg && pri_stop_req_i |=> sec_stopped)
		else $error("Request mode did not stop clock.");

	mode_idle_a: assert property (
		sec_en_reg && mode_reg && sec_bus_idle_i && !pri_req_pending_i
		|=> sec_stopped)
		else $error("Idle mode did not stop clock.");

	mode_busy_a: assert property (
		mode_reg && pri_req_pending_i |=> !sec_stopped)
		else $error("Clock stopped with a pending request.");

	rd_alias_a: assert property (
		opt_reg[OPT_P_RD - OPT_LSB]
		&& retry_cmd_i[0] == memory_read_line_cmd
		&& pend_cmd_i[0] == plain_memory_read_cmd |=> retry_match_o[0])
		else $error("Read alias did not match.");

	wr_exact_a: assert property (
		!opt_reg[OPT_S_WR - OPT_LSB]
		&& retry_cmd_i[1] == write_and_invalidate_cmd
		&& pend_cmd_i[1] == plain_memory_write_cmd |=> !retry_match_o[1])
		else $error("Write matched with alias off.");

	rlm_exact_a: assert property (
		!opt_reg[OPT_P_RLM - OPT_LSB] && !opt_reg[OPT_P_RD - OPT_LSB]
		&& retry_cmd_i[0] == memory_read_multiple_cmd
		&& pend_cmd_i[0] == memory_read_line_cmd |=> !retry_match_o[0])
		else $error("Line and multiple matched with alias off.");

	rd_alias_sec_a: assert property (
		opt_reg[OPT_S_RD - OPT_LSB]
		&& retry_cmd_i[1] == memory_read_multiple_cmd
		&& pend_cmd_i[1] == plain_memory_read_cmd |=> retry_match_o[1])
		else $error("Secondary read alias did not match.");

	rd_exact_a: assert property (
		!opt_reg[OPT_P_RD - OPT_LSB]
		&& retry_cmd_i[0] == memory_read_line_cmd
		&& pend_cmd_i[0] == plain_memory_read_cmd |=> !retry_match_o[0])
		else $error("Read matched with alias off.");

	rd_exact_sec_a: assert property (
		!opt_reg[OPT_S_RD - OPT_LSB]
		&& retry_cmd_i[1] == memory_read_multiple_cmd
		&& pend_cmd_i[1] == plain_memory_read_cmd |=> !retry_match_o[1])
		else $error("Secondary read matched with alias off.");

	wr_alias_a: assert property (
		opt_reg[OPT_P_WR - OPT_LSB] && pend_nonposted_i[0]
		&& retry_cmd_i[0] == write_and_invalidate_cmd
		&& pend_cmd_i[0] == plain_memory_write_cmd |=> retry_match_o[0])
		else $error("Write alias did not match.");

	wr_alias_sec_a: assert property (
		opt_reg[OPT_S_WR - OPT_LSB] && pend_nonposted_i[1]
		&& retry_cmd_i[1] == write_and_invalidate_cmd
		&& pend_cmd_i[1] == plain_memory_write_cmd |=> retry_match_o[1])
		else $error("Secondary write alias did not match.");

	wr_posted_a: assert property (
		!pend_nonposted_i[0]
		&& retry_cmd_i[0] == write_and_invalidate_cmd
		&& pend_cmd_i[0] == plain_memory_write_cmd |=> !retry_match_o[0])
		else $error("Posted write matched by alias.");

	rlm_alias_a: assert property (
		opt_reg[OPT_P_RLM - OPT_LSB]
		&& retry_cmd_i[0] == memory_read_multiple_cmd
		&& pend_cmd_i[0] == memory_read_line_cmd
		|=> retry_match_o[0])
		else $error("Line and multiple alias did not match.");

	rlm_sec_a: assert property (
		opt_reg[OPT_S_RLM - OPT_LSB]
		&& retry_cmd_i[1] == memory_read_line_cmd
		&& pend_cmd_i[1] == memory_read_multiple_cmd
		|=> retry_match_o[1])
		else $error("Secondary line and multiple alias did not match.");

	pri_keep_a: assert property (
		pri_keep_reg |-> !pri_clk_stop_ok_o)
		else $error("Primary stop allowed while kept running.");

	pri_off_a: assert property (
		!pri_en_reg |-> !pri_clk_stop_ok_o)
		else $error("Primary stop allowed while disabled.");

	set_beats_clr_c: cover property (serr_clr && serr_cause_i != '0);
	sec_stop_c: cover property (!sec_stopped ##1 sec_stopped);
	pri_allow_c: cover property (pri_clk_stop_ok_o);
	pri_keep_c: cover property (pri_keep_reg && sec_stopped);
	wr_alias_c: cover property (retry_match_o[1]
		&& opt_reg[OPT_S_WR - OPT_LSB]);

endmodule : bridge_error_clock_run_control_retry_options

`default_nettype wire

// ==== hdl/bridge_opts_pkg.sv ====
package bridge_opts_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SERR_STATUS = 8'h68;
	localparam logic [7:0] ADDR_CLOCK_RUN_CONTROL      = 8'h6C;
	localparam logic [7:0] ADDR_PORT_OPTION = 8'h74;
	localparam int         ADDR_W           = 8;
	localparam int         DATA_W           = 32;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SERR_LSB      = 16;
	localparam int SERR_W        = 8;
	localparam int CR_SEC_STOP   = 24;
	localparam int CR_SEC_EN     = 25;
	localparam int CR_PRI_KEEP   = 26;
	localparam int CR_PRI_EN     = 27;
	localparam int CR_MODE       = 28;
	localparam int OPT_P_RD      = 1;
	localparam int OPT_P_WR      = 2;
	localparam int OPT_S_RD      = 3;
	localparam int OPT_S_WR      = 4;
	localparam int OPT_P_RLM     = 5;
	localparam int OPT_S_RLM     = 6;
	localparam int OPT_LSB       = 1;
	localparam int OPT_W         = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [SERR_W-1:0] SERR_RST = 8'h00;
	localparam logic [OPT_W-1:0]  OPT_RST  = 6'h35;

	// ----------------------------------------------------------------
	// Bus commands
	// ----------------------------------------------------------------
	localparam logic [3:0] plain_memory_read_cmd    = 4'h6;
	localparam logic [3:0] plain_memory_write_cmd   = 4'h7;
	localparam logic [3:0] memory_read_multiple_cmd = 4'hC;
	localparam logic [3:0] memory_read_line_cmd     = 4'hE;
	localparam logic [3:0] write_and_invalidate_cmd = 4'hF;

	typedef enum logic {
		CLK_RUNNING,
		CLK_STOPPED
	} sec_clk_state_t;

endpackage : bridge_opts_pkg

// ==== dv/pci_peer_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pci_peer_model (
	// Clock
	input  wire logic       clk_i,
	// Error causes and clock-run levels
	output logic [7:0]      cause_o,
	output logic            stop_req_o,
	output logic            req_pending_o,
	output logic            bus_idle_o,
	// Retried and pending commands, index 0 primary
	output logic [1:0][3:0] retry_cmd_o,
	output logic [1:0][3:0] pend_cmd_o,
	output logic [1:0]      pend_nonposted_o
);
	initial begin
		cause_o          = 8'h00;
		stop_req_o       = 1'b0;
		req_pending_o    = 1'b0;
		bus_idle_o       = 1'b0;
		retry_cmd_o      = '0;
		pend_cmd_o       = '0;
		pend_nonposted_o = 2'h0;
	end

	// One cause for one cycle, as the error pin would be raised once.
	task automatic pulse(input int n);
		@(posedge clk_i);
		cause_o <= 8'h01 << n;
		@(posedge clk_i);
		cause_o <= 8'h00;
	endtask : pulse

	task automatic run(input logic req, input logic pend, input logic idle);
		@(posedge clk_i);
		stop_req_o    <= req;
		req_pending_o <= pend;
		bus_idle_o    <= idle;
	endtask : run

	// The initiator repeats its retried command while still pending.
	task automatic offer(input int pt, input logic [3:0] r,
		input logic [3:0] p, input logic np);
		@(posedge clk_i);
		retry_cmd_o[pt]      <= r;
		pend_cmd_o[pt]       <= p;
		pend_nonposted_o[pt] <= np;
	endtask : offer
endmodule : pci_peer_model

`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import bridge_opts_pkg::*;

	logic                 clk_i;
	logic                 srst_i;
	logic                 psel_i;
	logic                 penable_i;
	logic                 pwrite_i;
	logic [7:0]           paddr_i;
	logic [31:0]          pwdata_i;
	wire logic [31:0]     prdata_o;
	wire logic            pready_o;
	wire logic            pslverr_o;
	wire logic [7:0]      cause;
	wire logic            stop_req;
	wire logic            req_pending;
	wire logic            bus_idle;
	wire logic            sec_clk_stop_o;
	wire logic            pri_clk_stop_ok_o;
	wire logic [1:0][3:0] retry_cmd;
	wire logic [1:0][3:0] pend_cmd;
	wire logic [1:0]      pend_np;
	wire logic [1:0]      retry_match_o;
	int                   num_errors = 0;
	int                   compares = 0;

	bridge_error_clock_run_control_retry_options #(.PORTS(2)) u_bridge_error_clock_run_control_retry_options (
		.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .serr_cause_i(cause),
		.pri_stop_req_i(stop_req), .pri_req_pending_i(req_pending),
		.sec_bus_idle_i(bus_idle), .sec_clk_stop_o(sec_clk_stop_o),
		.pri_clk_stop_ok_o(pri_clk_stop_ok_o), .retry_cmd_i(retry_cmd),
		.pend_cmd_i(pend_cmd), .pend_nonposted_i(pend_np),
		.retry_match_o(retry_match_o));

	pci_peer_model u_peer (
		.clk_i(clk_i), .cause_o(cause), .stop_req_o(stop_req),
		.req_pending_o(req_pending), .bus_idle_o(bus_idle),
		.retry_cmd_o(retry_cmd), .pend_cmd_o(pend_cmd),
		.pend_nonposted_o(pend_np));

	// ----------------------------------------------------------------
	// Bus cycles and checks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Starting on a fresh edge keeps one idle cycle between transfers.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (pready_o !== 1'b1) begin
			num_errors++;
			$display("BAD %0t bus transfer got no ready", $time);
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
		input logic ee, input string what);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		chk(rd, exp, what);
		chk({31'h0, err}, {31'h0, ee}, what);
	endtask : rdchk

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		rdchk(ADDR_SERR_STATUS, 32'h0000_0000, 1'b0, "status");
		rdchk(ADDR_CLOCK_RUN_CONTROL, 32'h0000_0000, 1'b0, "clock_run_control");
		rdchk(ADDR_PORT_OPTION, 32'h0000_006A, 1'b0, "opt");
		wr(8'h70, 32'hFFFF_FFFF);
		rdchk(8'h70, 32'h0000_0000, 1'b1, "unmapped");
		rdchk(ADDR_PORT_OPTION, 32'h0000_006A, 1'b0, "opt kept");
		wr(ADDR_CLOCK_RUN_CONTROL, 32'hE100_0000);
		rdchk(ADDR_CLOCK_RUN_CONTROL, 32'h0000_0000, 1'b0, "clock_run_control ro");
		$display("test_reset done");
	endtask : test_reset

	task automatic test_causes();
		logic [31:0] m;
		for (int n = 0; n < 8; n++) begin
			m = 32'h0000_0001 << (16 + n);
			u_peer.pulse(n);
			rdchk(ADDR_SERR_STATUS, m, 1'b0, "set");
			wr(ADDR_SERR_STATUS, ~m);
			rdchk(ADDR_SERR_STATUS, m, 1'b0, "zero keeps");
			fork
				wr(ADDR_SERR_STATUS, m);
				begin
					@(posedge clk_i);
					u_peer.pulse(n);
				end
			join
			rdchk(ADDR_SERR_STATUS, m, 1'b0, "set wins");
			wr(ADDR_SERR_STATUS, m);
			rdchk(ADDR_SERR_STATUS, 32'h0000_0000, 1'b0, "cleared");
		end
		$display("test_causes done");
	endtask : test_causes

	task automatic cr(input logic [31:0] w, input logic req, input logic pend,
		input logic idle, input logic stop, input logic ok);
		wr(ADDR_CLOCK_RUN_CONTROL, w);
		u_peer.run(req, pend, idle);
		repeat (3) @(posedge clk_i);
		chk({31'h0, sec_clk_stop_o}, {31'h0, stop}, "stopped");
		chk({31'h0, pri_clk_stop_ok_o}, {31'h0, ok}, "pri ok");
		rdchk(ADDR_CLOCK_RUN_CONTROL, w | ({31'h0, stop} << 24), 1'b0, "clock_run_control rd");
	endtask : cr

	task automatic test_clock_run_control();
		cr(32'h0200_0000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		cr(32'h0A00_0000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		cr(32'h0E00_0000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		cr(32'h0A00_0000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		cr(32'h1A00_0000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
		cr(32'h1A00_0000, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		cr(32'h1800_0000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		$display("test_clock_run_control done");
	endtask : test_clock_run_control

	function automatic logic exp_match(input int pt, input logic [5:0] o,
		input logic [3:0] r, input logic [3:0] p, input logic np);
		logic rl;
		rl = (r == memory_read_line_cmd || r == memory_read_multiple_cmd);
		if (r == p) return 1'b1;
		if (rl && p == plain_memory_read_cmd) return o[pt ? 2 : 0];
		if (rl && (p == memory_read_line_cmd ||
			p == memory_read_multiple_cmd)) return o[pt ? 5 : 4];
		if (r == write_and_invalidate_cmd && p == plain_memory_write_cmd && np)
			return o[pt ? 3 : 1];
		return 1'b0;
	endfunction : exp_match

	task automatic test_match();
		logic [5:0] opts [3] = '{6'h35, 6'h00, 6'h3F};
		logic [3:0] rc [7] = '{4'hE, 4'hC, 4'hF, 4'hC, 4'hE, 4'hF, 4'h6};
		logic [3:0] pc [7] = '{4'h6, 4'h6, 4'h7, 4'hE, 4'hC, 4'h7, 4'hE};
		logic       npv [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		for (int o = 0; o < 3; o++) begin
			wr(ADDR_PORT_OPTION, {25'h0, opts[o], 1'b0});
			for (int pt = 0; pt < 2; pt++) begin
				for (int k = 0; k < 7; k++) begin
					u_peer.offer(pt, rc[k], pc[k], npv[k]);
					repeat (2) @(posedge clk_i);
					chk({31'h0, retry_match_o[pt]}, {31'h0, exp_match(pt, opts[o], rc[k], pc[k], npv[k])}, "match");
				end
			end
		end
		$display("test_match done");
	endtask : test_match

	task automatic test_rerun();
		wr(ADDR_CLOCK_RUN_CONTROL, 32'h1E00_0000);
		u_peer.pulse(7);
		@(posedge clk_i);
		chk({31'h0, sec_clk_stop_o}, 32'h0000_0001, "stop set");
		srst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		rdchk(ADDR_SERR_STATUS, 32'h0000_0000, 1'b0, "status rst");
		rdchk(ADDR_CLOCK_RUN_CONTROL, 32'h0000_0000, 1'b0, "clock_run_control rst");
		rdchk(ADDR_PORT_OPTION, 32'h0000_006A, 1'b0, "opt rst");
		chk({31'h0, sec_clk_stop_o}, 32'h0000_0000, "stop rst");
		$display("test_rerun done");
	endtask : test_rerun

	// ----------------------------------------------------------------
	// Run
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		#100000;
		num_errors++;
		final_report();
	end

	initial begin
		srst_i    = 1'b1;
		psel_i    = 1'b0;
		penable_i = 1'b0;
		pwrite_i  = 1'b0;
		paddr_i   = 8'h00;
		pwdata_i  = 32'h0000_0000;
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		test_reset();
		test_causes();
		test_clock_run_control();
		test_match();
		test_rerun();
		final_report();
	end
endmodule : testbench

`default_nettype wire
